/* logic/core_control.sv */
// Purpose: mode-control slice of a can controller core control register
// Assumes: avalon-mm slave with waitrequest, protocol engine in another clock domain
// Notes:   init readback comes back through the engine crossing and so lags a write
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "core_control_map.svh"
module core_control (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // protocol engine side
   input  wire logic        engine_idle,
   input  wire logic        engine_init_ack,
   output logic             init_request,
   output logic             config_access,
   output logic             restricted_op,
   output logic             clock_stop_ack
);
   import core_control_pkg::*;

   core_state_type s_q;
   core_state_type s_d;
   logic           idle_s;
   logic           init_ack_s;
   logic           accept;
   logic           wr_ctl;
   logic [31:0]    read_value;

   // engine idle comes from a pin in another domain
   sync_stage #(.RESET_VAL(1'b0)) idle_sync (
      .clock     (clock),
      .rst       (rst),
      .level_in  (engine_idle),
      .level_out (idle_s)
   );

   // init as taken by the engine, returned across the crossing
   sync_stage #(.RESET_VAL(`INIT_RESET)) init_sync (
      .clock     (clock),
      .rst       (rst),
      .level_in  (engine_init_ack),
      .level_out (init_ack_s)
   );

   always_comb begin
      read_value = 32'h0000_0000;
      case (address)
         `CORE_CONTROL_OFS: begin
            read_value[`BIT_INIT] = init_ack_s;
            read_value[`BIT_CFG_CHANGE] = s_q.config_change_enable;
            read_value[`BIT_RESTRICTED] = s_q.restricted_op_enable;
            read_value[`BIT_STOP_ACK]   = s_q.clock_stop_ack;
            read_value[`BIT_STOP_REQ]   = s_q.clock_stop_request;
         end
         `ENGINE_STATUS_OFS: begin
            read_value[`BIT_ENGINE_IDLE]  = idle_s;
            read_value[`BIT_INIT_PENDING] = s_q.init ^ init_ack_s;
         end
         default: read_value = 32'h0000_0000;
      endcase
   end

   assign accept = (read | write) & (s_q.bus == BUS_ANSWER);
   assign wr_ctl = write & accept & (address == `CORE_CONTROL_OFS) & byteenable[0];

   always_comb begin
      s_d = s_q;
      // one wait cycle per access; write and read data land at the low-waitrequest edge
      case (s_q.bus)
         BUS_IDLE: begin
            if (read | write) begin
               s_d.bus         = BUS_ANSWER;
               s_d.waitrequest = 1'b0;
               s_d.readdata    = read ? read_value : 32'h0000_0000;
            end
         end
         BUS_ANSWER: begin
            s_d.bus         = BUS_IDLE;
            s_d.waitrequest = 1'b1;
         end
         default: begin
            s_d.bus         = BUS_IDLE;
            s_d.waitrequest = 1'b1;
         end
      endcase
      if (wr_ctl) begin
         // a new init value is dropped while the last one is still crossing
         if (s_q.init == init_ack_s) begin
            s_d.init = writedata[`BIT_INIT];
         end
         if (init_ack_s) begin
            s_d.config_change_enable = writedata[`BIT_CFG_CHANGE];
         end
         if (!writedata[`BIT_RESTRICTED]) begin
            s_d.restricted_op_enable = 1'b0;
         end else if (s_q.config_change_enable && init_ack_s) begin
            s_d.restricted_op_enable = 1'b1;
         end
         s_d.clock_stop_request = writedata[`BIT_STOP_REQ];
      end
      // leaving init closes the protection window
      if (!init_ack_s) begin
         s_d.config_change_enable = 1'b0;
      end
      // acknowledge only once the engine is idle, withdrawn with the request
      if (!s_q.clock_stop_request) begin
         s_d.clock_stop_ack = 1'b0;
      end else if (idle_s) begin
         s_d.clock_stop_ack = 1'b1;
      end
      s_d.config_access = s_q.config_change_enable & init_ack_s;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q.bus                  <= BUS_IDLE;
         s_q.waitrequest          <= 1'b1;
         s_q.readdata             <= 32'h0000_0000;
         s_q.init                 <= `INIT_RESET;
         s_q.config_change_enable <= `CFG_CHANGE_RESET;
         s_q.restricted_op_enable <= `RESTRICTED_RESET;
         s_q.clock_stop_request   <= `STOP_REQ_RESET;
         s_q.clock_stop_ack       <= `STOP_ACK_RESET;
         s_q.config_access        <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata       = s_q.readdata;
   assign waitrequest    = s_q.waitrequest;
   assign init_request   = s_q.init;
   assign config_access  = s_q.config_access;
   assign restricted_op  = s_q.restricted_op_enable;
   assign clock_stop_ack = s_q.clock_stop_ack;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence bus_request_s;
      (s_q.bus == BUS_IDLE) && (read || write);
   endsequence

   sequence bus_answer_s;
      !waitrequest ##1 waitrequest;
   endsequence

   sequence ctl_read_s;
      bus_request_s and (read && (address == `CORE_CONTROL_OFS));
   endsequence

   sequence status_read_s;
      bus_request_s and (read && (address == `ENGINE_STATUS_OFS));
   endsequence

   sequence stray_read_s;
      bus_request_s and (read && (address != `CORE_CONTROL_OFS)
         && (address != `ENGINE_STATUS_OFS));
   endsequence

   sequence write_only_s;
      bus_request_s and (write && !read);
   endsequence

   sequence stop_armed_s;
      s_q.clock_stop_request && idle_s;
   endsequence

   // bus timing: one wait cycle, then back to idle
   bus_answer_once_a: assert property (bus_request_s |=> bus_answer_s)
      else $error("bus access not answered in one wait cycle");

   wait_low_once_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest held low for more than one cycle");

   idle_no_answer_a: assert property ((s_q.bus == BUS_IDLE) && !read && !write
      |=> waitrequest)
      else $error("waitrequest dropped with no access pending");

   write_data_zero_a: assert property (write_only_s
      |=> readdata == 32'h0000_0000)
      else $error("read data not cleared by a write access");

   stray_read_zero_a: assert property (stray_read_s
      |=> readdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");

   // clock stop handshake
   ack_needs_idle_a: assert property ($rose(clock_stop_ack)
      |-> $past(s_q.clock_stop_request) && $past(idle_s))
      else $error("clock stop acknowledge without request and idle engine");

   ack_rise_a: assert property (stop_armed_s
      |=> clock_stop_ack)
      else $error("clock stop acknowledge missing for idle engine");

   ack_readback_a: assert property (ctl_read_s
      |=> readdata[`BIT_STOP_ACK] == $past(clock_stop_ack))
      else $error("clock stop acknowledge readback wrong");

   idle_readback_a: assert property (status_read_s
      |=> readdata[`BIT_ENGINE_IDLE] == $past(idle_s))
      else $error("engine idle readback wrong");

   ack_held_low_a: assert property (!idle_s && !clock_stop_ack |=> !clock_stop_ack)
      else $error("clock stop acknowledge rose while engine busy");

   request_set_a: assert property (wr_ctl && writedata[`BIT_STOP_REQ]
      |=> s_q.clock_stop_request)
      else $error("clock stop request write lost");

   request_clear_a: assert property (wr_ctl && !writedata[`BIT_STOP_REQ]
      |=> !s_q.clock_stop_request)
      else $error("clock stop request clear lost");

   ack_withdraw_a: assert property (!s_q.clock_stop_request ##1 !s_q.clock_stop_request
      |-> !clock_stop_ack)
      else $error("clock stop acknowledge kept after request withdrawn");

   ack_drop_a: assert property (!s_q.clock_stop_request
      |=> !clock_stop_ack)
      else $error("clock stop acknowledge not dropped with request");

   ack_read_only_a: assert property (wr_ctl && writedata[`BIT_STOP_ACK]
      && !s_q.clock_stop_request |=> !clock_stop_ack)
      else $error("clock stop acknowledge written by software");

   // restricted operation and its protection window
   mode_readback_a: assert property (ctl_read_s
      |=> readdata[`BIT_RESTRICTED] == $past(restricted_op))
      else $error("restricted operation readback wrong");

   mode_set_gate_a: assert property ($rose(restricted_op)
      |-> $past(s_q.config_change_enable) && $past(init_ack_s))
      else $error("restricted operation set outside protection window");

   mode_set_a: assert property (wr_ctl && writedata[`BIT_RESTRICTED]
      && s_q.config_change_enable && init_ack_s |=> restricted_op)
      else $error("restricted operation set refused inside window");

   mode_blocked_a: assert property (wr_ctl && !restricted_op
      && !(s_q.config_change_enable && init_ack_s) |=> !restricted_op)
      else $error("restricted operation set outside window");

   mode_hold_a: assert property (!wr_ctl
      |=> $stable(restricted_op))
      else $error("restricted operation changed without a write");

   mode_clear_a: assert property (wr_ctl && !writedata[`BIT_RESTRICTED] |=> !restricted_op)
      else $error("restricted operation clear ignored");

   enable_gate_a: assert property ($rose(s_q.config_change_enable) |-> $past(init_ack_s))
      else $error("config change enable set while init not active");

   enable_clear_a: assert property (!init_ack_s
      |=> !s_q.config_change_enable)
      else $error("config change enable kept outside init");

   enable_write_a: assert property (wr_ctl && init_ack_s
      && writedata[`BIT_CFG_CHANGE] |=> s_q.config_change_enable)
      else $error("config change enable write lost during init");

   enable_hold_a: assert property (!wr_ctl && init_ack_s
      |=> $stable(s_q.config_change_enable))
      else $error("config change enable changed without a write");

   access_window_a: assert property (##1 config_access
      == ($past(s_q.config_change_enable) && $past(init_ack_s)))
      else $error("protected access does not follow enable and init");

   access_off_a: assert property (!init_ack_s
      |=> !config_access)
      else $error("protected access open outside init");

   // init crossing: one value in flight at a time
   init_hold_a: assert property (s_q.init != init_ack_s |=> $stable(init_request))
      else $error("init changed while previous value still crossing");

   init_write_a: assert property (wr_ctl && (init_request == init_ack_s)
      && writedata[`BIT_INIT] |=> init_request)
      else $error("init set lost after previous value accepted");

   init_clear_a: assert property (wr_ctl && (init_request == init_ack_s)
      && !writedata[`BIT_INIT] |=> !init_request)
      else $error("init clear lost after previous value accepted");

   init_steady_a: assert property (!wr_ctl
      |=> $stable(init_request))
      else $error("init changed without a write");

   init_readback_a: assert property (ctl_read_s
      |=> readdata[`BIT_INIT] == $past(init_ack_s))
      else $error("init readback does not show the crossed value");

   pending_readback_a: assert property (status_read_s
      |=> readdata[`BIT_INIT_PENDING] == ($past(init_request) != $past(init_ack_s)))
      else $error("init pending flag wrong");

endmodule : core_control

/* logic/core_control_map.svh */
// Purpose: offsets, field positions, reset values and timing counts of the core control slice
// Assumes: byte addressed avalon slave, one 32-bit word per register
// Notes:   the bit map numbers bits msb-first (bit 31 is the lsb); positions here are lsb-based
`ifndef CORE_CONTROL_MAP_SVH
`define CORE_CONTROL_MAP_SVH

// register byte offsets
`define CORE_CONTROL_OFS   4'h0
`define ENGINE_STATUS_OFS  4'h4

// core_control fields (msb-first bit n sits at lsb position 31-n)
`define BIT_INIT           0
`define BIT_CFG_CHANGE     1
`define BIT_RESTRICTED     2
`define BIT_STOP_ACK       3
`define BIT_STOP_REQ       4

// engine_status fields
`define BIT_ENGINE_IDLE    0
`define BIT_INIT_PENDING   1

// reset values
`define INIT_RESET         1'h1
`define CFG_CHANGE_RESET   1'h0
`define RESTRICTED_RESET   1'h0
`define STOP_REQ_RESET     1'h0
`define STOP_ACK_RESET     1'h0

// flip-flops in each crossing back from the protocol engine
`define SYNC_STAGES        2

`endif

/* logic/core_control_pkg.sv */
// Purpose: types of the core control slice
// Assumes: constants come from core_control_map.svh
// Notes:   bus state is one-hot
package core_control_pkg;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_type;

   typedef struct packed {
      bus_state_type bus;
      logic          waitrequest;
      logic [31:0]   readdata;
      logic          init;
      logic          config_change_enable;
      logic          restricted_op_enable;
      logic          clock_stop_request;
      logic          clock_stop_ack;
      logic          config_access;
   } core_state_type;

endpackage : core_control_pkg

/* logic/sync_stage.sv */
// Purpose: two flip-flop synchroniser for single-bit levels
// Assumes: input is a level, stable for at least two clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sync_stage #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // level
   input  wire logic level_in,
   output logic      level_out
);

   logic meta_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q    <= RESET_VAL;
         level_out <= RESET_VAL;
      end else begin
         meta_q    <= level_in;
         level_out <= meta_q;
      end
   end

endmodule : sync_stage

/* verification/engine_model.sv */
// Purpose: protocol engine stand-in facing the core control slice
// Assumes: init is taken after a fixed lag, idle is commanded by the bench
// Notes:   the lag makes init readback trail a write, as a real crossing does
`timescale 1ns/1ps
module engine_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // register side
   input  wire logic init_request,
   input  wire logic go_idle,
   // engine answers
   output logic      engine_init_ack,
   output logic      engine_idle
);
   logic [3:0] lag_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         lag_q <= 4'hf;
      end else begin
         lag_q <= {lag_q[2:0], init_request};
      end
   end
   // long lag so a second init write lands while the first is pending
   assign engine_init_ack = lag_q[3];
   assign engine_idle     = go_idle;
endmodule : engine_model

/* verification/test_core_control.sv */
// Purpose: self-checking bench of the core control slice
// Assumes: avalon master tasks, engine stand-in with init lag
// Notes:   byteenable tied to all lanes; lane gating is left untested
`timescale 1ns/1ps
`include "core_control_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_core_control;
   localparam logic [3:0] CC = `CORE_CONTROL_OFS;
   localparam logic [3:0] ST = `ENGINE_STATUS_OFS;
   logic        clock     = 1'b0;
   logic        rst       = 1'b1;
   logic [3:0]  address   = 4'h0;
   logic        read      = 1'b0;
   logic        write     = 1'b0;
   logic        go_idle   = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic        waitrequest, engine_idle, engine_init_ack, init_request;
   logic        config_access, restricted_op, clock_stop_ack;
   int          err_count = 0;
   int          n_tests   = 0;
   int          i;
   always #4 clock = ~clock;
   core_control DUT (.clock(clock), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .engine_idle(engine_idle),
      .engine_init_ack(engine_init_ack), .init_request(init_request),
      .config_access(config_access), .restricted_op(restricted_op),
      .clock_stop_ack(clock_stop_ack));
   engine_model far (.clock(clock), .rst(rst), .init_request(init_request),
      .go_idle(go_idle), .engine_init_ack(engine_init_ack), .engine_idle(engine_idle));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= ~w;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      if (waitrequest !== 1'b0) begin
         err_count++;
         $display("[FAIL] %0t bus timeout", $time);
         give_verdict();
      end
   endtask : acc
   task automatic wr(input logic [31:0] d);
      acc(1'b1, CC, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd
   // poll until the engine has taken the last init value
   task automatic settle();
      for (i = 0; i < 20; i++) begin
         acc(1'b0, ST, 32'h0);
         if (q[`BIT_INIT_PENDING] === 1'b0) break;
      end
      `CHK(q[`BIT_INIT_PENDING], 1'b0)
   endtask : settle
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(CC, 32'h1);
      `CHK(clock_stop_ack, 1'b0)
      wr(32'h5);
      rd(CC, 32'h1);
      wr(32'h3);
      rd(CC, 32'h3);
      `CHK(config_access, 1'b1)
      wr(32'h7);
      rd(CC, 32'h7);
      `CHK(restricted_op, 1'b1)
      wr(32'hf);
      rd(CC, 32'h7);
      wr(32'h4);
      settle();
      `CHK(init_request, 1'b0)
      rd(CC, 32'h4);
      `CHK(config_access, 1'b0)
      wr(32'h6);
      rd(CC, 32'h4);
      wr(32'h0);
      rd(CC, 32'h0);
      `CHK(restricted_op, 1'b0)
      // second init write lands while the first is still crossing
      wr(32'h1);
      wr(32'h0);
      settle();
      rd(CC, 32'h1);
      `CHK(init_request, 1'b1)
      wr(32'h11);
      rd(ST, 32'h0);
      `CHK(clock_stop_ack, 1'b0)
      go_idle <= 1'b1;
      for (i = 0; i < 20 && clock_stop_ack !== 1'b1; i++) @(posedge clock);
      `CHK(clock_stop_ack, 1'b1)
      rd(CC, 32'h19);
      rd(ST, 32'h1);
      wr(32'h1);
      rd(CC, 32'h1);
      `CHK(clock_stop_ack, 1'b0)
      acc(1'b1, 4'h8, 32'hffffffff);
      rd(4'h8, 32'h0);
      rd(CC, 32'h1);
      give_verdict();
   end
endmodule : test_core_control
